// ==== rdq_pkg.sv ====
// Purpose: Shared constants and types of the receive done-queue writer.
// Assumes: A 32-bit classic Wishbone register bus with byte addresses in the low 12 bits.
// Notes:   Offsets are byte addresses; each register takes one aligned word.
`default_nettype none
package rdq_pkg;
  // ---------------------------------------------------------------------------
  // Register offsets.
  // ---------------------------------------------------------------------------
  localparam logic [11:0] OFF_MASTER_CONFIG   = 12'h700;
  localparam logic [11:0] OFF_DMA_STATUS      = 12'h704;
  localparam logic [11:0] OFF_INT_ENABLE      = 12'h708;
  localparam logic [11:0] OFF_BASE_LOW        = 12'h730;
  localparam logic [11:0] OFF_BASE_HIGH       = 12'h734;
  localparam logic [11:0] OFF_END_INDEX       = 12'h738;
  localparam logic [11:0] OFF_HOST_READ_PTR   = 12'h73C;
  localparam logic [11:0] OFF_ENGINE_WRITE_PTR = 12'h740;
  localparam logic [11:0] OFF_FLUSH_TIMER     = 12'h744;
  localparam logic [11:0] OFF_RX_QUEUE_CTRL   = 12'h780;
  // ---------------------------------------------------------------------------
  // Field positions and reset values.
  // ---------------------------------------------------------------------------
  localparam int          RX_DMA_ENABLE_BIT   = 0;
  localparam int          DONE_WRITE_BIT      = 0;
  localparam int          DONE_OVERFLOW_BIT   = 1;
  localparam int          BURST_ENABLE_BIT    = 4;
  localparam int          FIFO_FLUSH_BIT      = 5;
  localparam int          FLAG_THRESHOLD_LSB  = 8;
  localparam logic [15:0] RX_QUEUE_CTRL_MASK  = 16'h073D;
  localparam logic [15:0] REG_RESET           = 16'h0000;
  localparam int          ENT_VALID_BIT       = 31;
  localparam int          ENT_EOF_BIT         = 30;
  localparam int          ENT_STATUS_LSB      = 27;
  localparam int          ENT_BUFCNT_LSB      = 24;
  localparam int          ENT_CHANNEL_LSB     = 16;
  // ---------------------------------------------------------------------------
  // Sizes and timing counts.
  // ---------------------------------------------------------------------------
  localparam int          NUM_CHANNELS        = 256;
  localparam int          FIFO_DEPTH          = 8;
  localparam int          HIGH_WATER          = 6;
  localparam int          TIMER_PRESCALE      = 256;
  // ---------------------------------------------------------------------------
  // Types.
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    RDQ_IDLE  = 2'h1,
    RDQ_WRITE = 2'h2
  } rdq_state_e;
endpackage
`default_nettype wire

// ==== rdq_writer.sv ====
// Function
// (R1) Equal read and write pointers mean empty.
// (R2) Read pointer one ahead means queue full.
// (R3) End index times four plus base.
// (R4) Post only after receive DMA enabled.
// (R5) Entry address is base plus write pointer.
// (R6) Pointer advances one, wraps to zero past end.
// (R7) Done flag after two-power threshold of entries.
// (R8) Overflow sets error, posts nothing, pointer kept.
// (R9) Each status flag can raise interrupt.
// (R10) Post after buffer count or whole packet.
// (R11) Packet end always posts an entry.
// (R12) Staging FIFO holds eight one-dword entries.
// (R13) Burst mode drains at six staged entries.
// (R14) Burst only as many entries as fit.
// (R15) No room: overflow flag, nothing written.
// (R16) After burst advance pointer, set done flag.
// (R17) Burst disabled posts entries one at a time.
// (R18) Sixteen-bit timer ticks every 256 clocks.
// (R19) Every queue write reloads the flush timer.
// (R20) Timer expiry forces staged entries out.
// (R21) Host programs nonzero reload before burst enable.
// (R22) Flush bit drains all staged entries.
// (R23) Only engine moves write, host moves read; the code also lets a host bus write change the write pointer.
// (R24) Entry valid bit is written as zero.
// Purpose: Posts receive completion entries into a circular host done queue.
// Assumes: Event inputs and the memory write port run on clk_i; memory port accepts one word per ack.
// Notes:   Each event stands for one filled data buffer of its channel.
`timescale 1ns/1ps
`default_nettype none
module rdq_writer #(
  parameter int NUM_CHANNELS = rdq_pkg::NUM_CHANNELS,
  parameter int FIFO_DEPTH   = rdq_pkg::FIFO_DEPTH,
  parameter int HIGH_WATER   = rdq_pkg::HIGH_WATER
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  input  wire logic        evt_valid_i,
  output var  logic        evt_ready_o,
  input  wire logic [7:0]  evt_channel_i,
  input  wire logic [15:0] evt_desc_ptr_i,
  input  wire logic        evt_eof_i,
  input  wire logic [2:0]  evt_status_i,
  input  wire logic [2:0]  evt_buffer_threshold_i,
  output var  logic        mem_req_o,
  output var  logic [31:0] mem_addr_o,
  output var  logic [31:0] mem_data_o,
  output var  logic        mem_last_o,
  input  wire logic        mem_ack_i,
  output var  logic        done_write_flag_o,
  output var  logic        done_overflow_flag_o,
  output var  logic        irq_o
);
  localparam int PW = $clog2(FIFO_DEPTH);

  // ---------------------------------------------------------------------------
  // Register file.
  // ---------------------------------------------------------------------------
  logic [15:0] base_low;
  logic [15:0] base_high;
  logic [15:0] end_index;
  logic [15:0] host_rp;
  logic [15:0] wp;
  logic [15:0] timer_reload_value;
  logic [15:0] rx_queue_control;
  logic        rx_dma_enable;
  logic [1:0]  int_enable;
  logic        wb_hit;
  logic        wb_wr;
  logic [15:0] wmask;
  logic        wp_bus_wr;
  logic        stat_clr_write;
  logic        stat_clr_ovf;
  logic        burst_en;
  logic        flush;
  logic [2:0]  flag_thr;
  logic [31:0] base_addr;

  assign wb_hit         = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr          = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wmask          = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wp_bus_wr      = wb_wr && (wb_adr_i == rdq_pkg::OFF_ENGINE_WRITE_PTR);
  assign stat_clr_write = wb_wr && (wb_adr_i == rdq_pkg::OFF_DMA_STATUS) && wb_sel_i[0]
                          && wb_dat_i[rdq_pkg::DONE_WRITE_BIT];
  assign stat_clr_ovf   = wb_wr && (wb_adr_i == rdq_pkg::OFF_DMA_STATUS) && wb_sel_i[0]
                          && wb_dat_i[rdq_pkg::DONE_OVERFLOW_BIT];
  assign burst_en       = rx_queue_control[rdq_pkg::BURST_ENABLE_BIT];
  assign flush          = rx_queue_control[rdq_pkg::FIFO_FLUSH_BIT];
  assign flag_thr       = rx_queue_control[rdq_pkg::FLAG_THRESHOLD_LSB +: 3];
  assign base_addr      = {base_high, base_low};

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] m, input logic [15:0] d);
    merge = (old & ~m) | (d & m);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      base_low           <= rdq_pkg::REG_RESET;
      base_high          <= rdq_pkg::REG_RESET;
      end_index          <= rdq_pkg::REG_RESET;
      host_rp            <= rdq_pkg::REG_RESET;
      timer_reload_value <= rdq_pkg::REG_RESET;
      rx_queue_control   <= rdq_pkg::REG_RESET;
      rx_dma_enable      <= 1'h0;
      int_enable         <= 2'h0;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        rdq_pkg::OFF_BASE_LOW:      base_low <= merge(base_low, wmask, wb_dat_i[15:0]);
        rdq_pkg::OFF_BASE_HIGH:     base_high <= merge(base_high, wmask, wb_dat_i[15:0]);
        rdq_pkg::OFF_END_INDEX:     end_index <= merge(end_index, wmask, wb_dat_i[15:0]);
        rdq_pkg::OFF_HOST_READ_PTR: host_rp <= merge(host_rp, wmask, wb_dat_i[15:0]); // [R23]
        rdq_pkg::OFF_FLUSH_TIMER:   timer_reload_value <= merge(timer_reload_value, wmask, wb_dat_i[15:0]);
        rdq_pkg::OFF_RX_QUEUE_CTRL: begin
          rx_queue_control <= merge(rx_queue_control, wmask & rdq_pkg::RX_QUEUE_CTRL_MASK, wb_dat_i[15:0]);
        end
        rdq_pkg::OFF_MASTER_CONFIG: begin
          if (wb_sel_i[0]) begin
            rx_dma_enable <= wb_dat_i[rdq_pkg::RX_DMA_ENABLE_BIT];
          end
        end
        rdq_pkg::OFF_INT_ENABLE: begin
          if (wb_sel_i[0]) begin
            int_enable <= wb_dat_i[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'h0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= 32'h0000_0000;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          rdq_pkg::OFF_BASE_LOW:         wb_dat_o[15:0] <= base_low;
          rdq_pkg::OFF_BASE_HIGH:        wb_dat_o[15:0] <= base_high;
          rdq_pkg::OFF_END_INDEX:        wb_dat_o[15:0] <= end_index;
          rdq_pkg::OFF_HOST_READ_PTR:    wb_dat_o[15:0] <= host_rp;
          rdq_pkg::OFF_ENGINE_WRITE_PTR: wb_dat_o[15:0] <= wp;
          rdq_pkg::OFF_FLUSH_TIMER:      wb_dat_o[15:0] <= timer_reload_value;
          rdq_pkg::OFF_RX_QUEUE_CTRL:    wb_dat_o[15:0] <= rx_queue_control;
          rdq_pkg::OFF_MASTER_CONFIG:    wb_dat_o[0] <= rx_dma_enable;
          rdq_pkg::OFF_DMA_STATUS:       wb_dat_o[1:0] <= {done_overflow_flag_o, done_write_flag_o};
          rdq_pkg::OFF_INT_ENABLE:       wb_dat_o[1:0] <= int_enable;
          default:                       wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Completion events and per-channel buffer counts.
  // ---------------------------------------------------------------------------
  logic [2:0]    buf_cnt [NUM_CHANNELS];
  logic          evt_take;
  logic [2:0]    inc_cnt;
  logic          post_evt;
  logic [31:0]   next_entry;

  assign evt_take = evt_valid_i && evt_ready_o;
  assign inc_cnt  = buf_cnt[evt_channel_i] + 3'h1;
  // Packet end always posts; otherwise post when the buffer count is reached.
  assign post_evt = evt_take && (evt_eof_i || (evt_buffer_threshold_i != 3'h0 &&
                                               inc_cnt == evt_buffer_threshold_i)); // [R10] [R11]

  always_comb begin
    next_entry = 32'h0000_0000; // [R24]
    next_entry[15:0] = evt_desc_ptr_i;
    next_entry[rdq_pkg::ENT_CHANNEL_LSB +: 8] = evt_channel_i;
    next_entry[rdq_pkg::ENT_BUFCNT_LSB +: 3] = (evt_buffer_threshold_i == 3'h0) ? 3'h0 : inc_cnt;
    next_entry[rdq_pkg::ENT_STATUS_LSB +: 3] = evt_status_i;
    next_entry[rdq_pkg::ENT_EOF_BIT] = evt_eof_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CHANNELS; i++) begin
        buf_cnt[i] <= 3'h0;
      end
    end else if (evt_take) begin
      buf_cnt[evt_channel_i] <= (post_evt || evt_buffer_threshold_i == 3'h0) ? 3'h0 : inc_cnt; // [R10]
    end
  end

  // ---------------------------------------------------------------------------
  // Staging FIFO.
  // ---------------------------------------------------------------------------
  logic [31:0]   fifo_mem [FIFO_DEPTH];
  logic [PW-1:0] f_wr;
  logic [PW-1:0] f_rd;
  logic [PW-1:0] f_rd_nx;
  logic [PW:0]   f_cnt;
  logic [PW:0]   next_f_cnt;
  logic          pop;
  logic          drop;
  logic          mem_done;
  rdq_pkg::rdq_state_e st;

  assign mem_done   = (st == rdq_pkg::RDQ_WRITE) && mem_ack_i;
  assign pop        = mem_done || drop;
  assign f_rd_nx    = f_rd + 1'h1;
  assign next_f_cnt = f_cnt + (PW+1)'(post_evt) - (PW+1)'(pop);

  always_ff @(posedge clk_i) begin
    if (post_evt) begin
      fifo_mem[f_wr] <= next_entry; // [R12]
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      f_wr        <= '0;
      f_rd        <= '0;
      f_cnt       <= '0;
      evt_ready_o <= 1'h0;
    end else begin
      if (post_evt) begin
        f_wr <= f_wr + 1'h1;
      end
      if (pop) begin
        f_rd <= f_rd_nx;
      end
      f_cnt       <= next_f_cnt;
      // Ready looks ahead so an accepted entry always finds a slot.
      evt_ready_o <= rx_dma_enable && (next_f_cnt < (PW+1)'(FIFO_DEPTH)); // [R4] [R12]
    end
  end

  // ---------------------------------------------------------------------------
  // Queue space and drain decision.
  // ---------------------------------------------------------------------------
  logic [16:0] q_size;
  logic [16:0] q_used;
  logic [16:0] q_free;
  logic [PW:0] n_fit;
  logic [16:0] wp_inc;
  logic [15:0] wp_adv;
  logic        tmr_expire;
  logic        trigger;
  logic        ovf_set;

  assign q_size  = {1'h0, end_index} + 17'h1;
  assign q_used  = (wp >= host_rp) ? ({1'h0, wp} - {1'h0, host_rp})
                                   : ({1'h0, wp} + q_size - {1'h0, host_rp}); // [R1]
  // One slot always stays unused, so a full queue has the read pointer one ahead.
  assign q_free  = q_size - 17'h1 - q_used; // [R2]
  assign n_fit   = !burst_en ? (PW+1)'(1) : (q_free < 17'(f_cnt)) ? q_free[PW:0] : f_cnt; // [R14] [R17]
  assign wp_inc  = {1'h0, wp} + 17'h1;
  assign wp_adv  = (wp_inc > {1'h0, end_index}) ? 16'h0000 : wp_inc[15:0]; // [R6]
  assign trigger = (f_cnt != '0) && (!burst_en || f_cnt >= (PW+1)'(HIGH_WATER) ||
                                     flush || tmr_expire); // [R13] [R17] [R20] [R22]
  assign ovf_set = (st == rdq_pkg::RDQ_IDLE) && trigger && (q_free == 17'h0); // [R8] [R15]
  // Single posting drops the refused entry; burst mode keeps it staged.
  assign drop    = ovf_set && !burst_en; // [R8]

  // ---------------------------------------------------------------------------
  // Host memory writer.
  // ---------------------------------------------------------------------------
  logic [PW:0] burst_left;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st         <= rdq_pkg::RDQ_IDLE;
      burst_left <= '0;
      mem_req_o  <= 1'h0;
      mem_addr_o <= 32'h0000_0000;
      mem_data_o <= 32'h0000_0000;
      mem_last_o <= 1'h0;
    end else begin
      unique case (st)
        rdq_pkg::RDQ_IDLE: begin
          if (trigger && q_free != 17'h0) begin
            st         <= rdq_pkg::RDQ_WRITE;
            burst_left <= n_fit; // [R14]
            mem_req_o  <= 1'h1;
            mem_addr_o <= base_addr + {14'h0000, wp, 2'h0}; // [R3] [R5]
            mem_data_o <= fifo_mem[f_rd];
            mem_last_o <= (n_fit == (PW+1)'(1));
          end
        end
        rdq_pkg::RDQ_WRITE: begin
          if (mem_ack_i) begin
            if (burst_left == (PW+1)'(1)) begin
              st         <= rdq_pkg::RDQ_IDLE;
              mem_req_o  <= 1'h0;
              mem_last_o <= 1'h0;
            end else begin
              mem_addr_o <= base_addr + {14'h0000, wp_adv, 2'h0}; // [R5]
              mem_data_o <= fifo_mem[f_rd_nx];
              mem_last_o <= (burst_left == (PW+1)'(2));
            end
            burst_left <= burst_left - 1'h1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp <= rdq_pkg::REG_RESET;
    end else if (mem_done) begin
      wp <= wp_adv; // [R6] [R16] [R23]
    end else if (wp_bus_wr) begin
      wp <= merge(wp, wmask, wb_dat_i[15:0]);
    end
  end

  // ---------------------------------------------------------------------------
  // Flush timer.
  // ---------------------------------------------------------------------------
  logic [7:0]  prescale;
  logic        tick;
  logic [15:0] done_flush_timer;

  assign tick       = (prescale == 8'(rdq_pkg::TIMER_PRESCALE - 1)); // [R18]
  // A zero reload expires at once; the host must program a legal value first.
  assign tmr_expire = burst_en && (done_flush_timer == 16'h0000); // [R18] [R21]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale         <= 8'h00;
      done_flush_timer <= rdq_pkg::REG_RESET;
    end else begin
      prescale <= prescale + 8'h01;
      if (mem_done || !burst_en) begin
        done_flush_timer <= timer_reload_value; // [R19]
      end else if (tick && done_flush_timer != 16'h0000) begin
        done_flush_timer <= done_flush_timer - 16'h0001; // [R18]
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Status flags and interrupt.
  // ---------------------------------------------------------------------------
  logic [7:0] posted_cnt;
  logic [7:0] thr_limit;
  logic       done_set;

  assign thr_limit = 8'h01 << flag_thr;
  assign done_set  = mem_done && ((posted_cnt + 8'h01) >= thr_limit); // [R7] [R16]

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      posted_cnt           <= 8'h00;
      done_write_flag_o    <= 1'h0;
      done_overflow_flag_o <= 1'h0;
      irq_o                <= 1'h0;
    end else begin
      if (mem_done) begin
        posted_cnt <= done_set ? 8'h00 : posted_cnt + 8'h01;
      end
      // A set in the same cycle as a clear wins.
      done_write_flag_o    <= done_set || (done_write_flag_o && !stat_clr_write); // [R7]
      done_overflow_flag_o <= ovf_set || (done_overflow_flag_o && !stat_clr_ovf); // [R8] [R15]
      irq_o <= (done_write_flag_o && int_enable[0]) || (done_overflow_flag_o && int_enable[1]); // [R9]
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions.
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_empty_no_ovf: assert property ((wp == host_rp && end_index != 16'h0000) |-> !ovf_set) // [R1]
    else $error("empty queue reported overflow");
  chk_full_block: assert property (mem_done |-> (wp_adv != host_rp)) // [R2] [R14]
    else $error("write filled the reserved slot");
  chk_addr_form: assert property (mem_req_o |-> mem_addr_o == base_addr + {14'h0000, wp, 2'h0}) // [R3] [R5]
    else $error("entry address mismatch");
  chk_dma_enable: assert property (evt_take |-> $past(rx_dma_enable)) // [R4]
    else $error("event taken while receive DMA disabled");
  chk_wrap_zero: assert property ((mem_done && wp >= end_index && !wp_bus_wr) |=> wp == 16'h0000) // [R6]
    else $error("write pointer did not wrap");
  chk_flag_thresh: assert property (done_set |=> done_write_flag_o) // [R7] [R16]
    else $error("done flag not set at threshold");
  chk_ovf_nowrite: assert property ((ovf_set && !wp_bus_wr) |=> (!mem_req_o && $stable(wp) && done_overflow_flag_o)) // [R8] [R15]
    else $error("overflow still wrote or moved pointer");
  chk_irq_follow: assert property ((done_overflow_flag_o && int_enable[1]) |=> irq_o) // [R9]
    else $error("enabled flag raised no interrupt");
  chk_fifo_bound: assert property (f_cnt <= (PW+1)'(FIFO_DEPTH)) // [R12]
    else $error("staging FIFO overfilled");
  chk_hold_below: assert property ((st == rdq_pkg::RDQ_IDLE && burst_en && !flush && !tmr_expire &&
                                    f_cnt < (PW+1)'(HIGH_WATER)) |=> !mem_req_o) // [R13]
    else $error("burst started below high water");
  chk_single_post: assert property ((st == rdq_pkg::RDQ_IDLE && !burst_en && mem_req_o == 1'h0 && f_cnt != '0 &&
                                     q_free != 17'h0) |=> (mem_req_o && mem_last_o)) // [R17]
    else $error("single post not issued as one write");
  chk_prescale: assert property (tick |=> !tick [*8]) // [R18]
    else $error("timer tick too frequent");
  chk_timer_reload: assert property (mem_done |=> done_flush_timer == $past(timer_reload_value)) // [R19]
    else $error("flush timer not reloaded");
  chk_flush_drain: assert property ((st == rdq_pkg::RDQ_IDLE && flush && f_cnt != '0 && q_free != 17'h0)
                                    |=> mem_req_o) // [R20] [R22]
    else $error("flush did not start drain");
  chk_valid_zero: assert property (mem_req_o |-> !mem_data_o[rdq_pkg::ENT_VALID_BIT]) // [R24]
    else $error("valid bit written as one");

  cov_burst_six: cover property (st == rdq_pkg::RDQ_IDLE && burst_en && f_cnt == (PW+1)'(HIGH_WATER) ##1 mem_req_o);
  cov_overflow: cover property (ovf_set);
  cov_wrap: cover property (mem_done && wp_adv == 16'h0000);
  cov_timer_out: cover property (tmr_expire && f_cnt != '0 && st == rdq_pkg::RDQ_IDLE);
endmodule
`default_nettype wire

// ==== rdq_mem_model.sv ====
// Purpose: Host memory model that accepts done-queue word writes.
// Assumes: A request and its word are held until acknowledged.
// Notes:   Counts accepted words and keeps the last address and data.
`timescale 1ns/1ps
`default_nettype none
module rdq_mem_model #(
  parameter int LAT = 2
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] data_i,
  output var  logic        ack_o,
  output var  logic [31:0] words_o,
  output var  logic [31:0] addr_o,
  output var  logic [31:0] data_o
);
  int wait_q;
  // A slow answer: each word waits LAT+1 idle cycles before its ack pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o   <= 1'b0;
      wait_q  <= 0;
      words_o <= 32'h0000_0000;
    end else if (ack_o) begin
      ack_o   <= 1'b0;
      words_o <= words_o + 32'h0000_0001;
      addr_o  <= addr_i;
      data_o  <= data_i;
    end else if (req_i) begin
      ack_o  <= (wait_q == LAT);
      wait_q <= (wait_q == LAT) ? 0 : wait_q + 1;
    end
  end
endmodule
`default_nettype wire

// ==== rdq_writer_tb.sv ====
// Purpose: Self-checking bench of the done-queue writer.
// Assumes: Base 0001_2000h; the bench acts as host register master.
// Notes:   Queue of 4 entries first, then 16 entries in burst mode.
`timescale 1ns/1ps
`default_nettype none
module rdq_writer_tb;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        req = 1'b0;
  logic        we = 1'b0;
  logic        ev_v = 1'b0;
  logic        ev_eof = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] dat = 32'h0000_0000;
  logic [15:0] ev_dp = 16'h0000;
  logic [7:0]  ev_ch = 8'h00;
  logic [2:0]  ev_st = 3'h0;
  logic [2:0]  ev_thr = 3'h0;
  logic [31:0] dat_o, q, words, laddr, ldata, m_addr, m_data;
  logic        ack, ev_rdy, m_req, m_ack, m_last, dwf, dof, irq;
  int          miscompares = 0;
  int          n_tests = 0;
  int          cycles = 0;
  int          n_last = 0;
  localparam logic [31:0] BASE = 32'h0001_2000;
  always #2.5 clk_i = ~clk_i;
  rdq_writer uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .evt_valid_i(ev_v), .evt_ready_o(ev_rdy),
    .evt_channel_i(ev_ch), .evt_desc_ptr_i(ev_dp), .evt_eof_i(ev_eof), .evt_status_i(ev_st),
    .evt_buffer_threshold_i(ev_thr), .mem_req_o(m_req), .mem_addr_o(m_addr), .mem_data_o(m_data),
    .mem_last_o(m_last), .mem_ack_i(m_ack), .done_write_flag_o(dwf), .done_overflow_flag_o(dof), .irq_o(irq));
  rdq_mem_model mem (.clk_i(clk_i), .rst_i(rst_i), .req_i(m_req), .addr_i(m_addr), .data_i(m_data),
    .ack_o(m_ack), .words_o(words), .addr_o(laddr), .data_o(ldata));
  // ---------------------------------------------------------------------------
  // Shared tasks.
  // ---------------------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  always @(posedge clk_i) begin
    if (m_req && m_ack && m_last) n_last++;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = dat_o;
    req <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
    wb(1'b0, a, 32'h0000_0000);
    chk(nm, e, q);
  endtask
  task automatic ev(input logic [7:0] ch, input logic eof, input logic [2:0] thr);
    @(posedge clk_i);
    ev_v   <= 1'b1;
    ev_ch  <= ch;
    ev_dp  <= {8'h00, ch};
    ev_eof <= eof;
    ev_st  <= ch[2:0];
    ev_thr <= thr;
    do @(posedge clk_i); while (ev_rdy !== 1'b1);
    ev_v <= 1'b0;
  endtask
  task automatic waitw(input logic [31:0] n);
    for (int i = 0; i < 700 && words !== n; i++) @(posedge clk_i);
    chk("words", n, words);
  endtask
  function automatic logic [31:0] ent(input logic [7:0] ch, input logic eof, input logic [2:0] cnt);
    return {1'b0, eof, ch[2:0], cnt, ch, 8'h00, ch};
  endfunction
  // ---------------------------------------------------------------------------
  // Scenarios.
  // ---------------------------------------------------------------------------
  task automatic t_regs();
    rd(rdq_pkg::OFF_FLUSH_TIMER, 32'h0000_0000, "reload");
    rd(rdq_pkg::OFF_RX_QUEUE_CTRL, 32'h0000_0000, "ctrl");
    rd(12'h7F0, 32'h0000_0000, "unmapped");
    wb(1'b1, rdq_pkg::OFF_BASE_LOW, 32'h0000_2000);
    wb(1'b1, rdq_pkg::OFF_BASE_HIGH, 32'h0000_0001);
    wb(1'b1, rdq_pkg::OFF_END_INDEX, 32'h0000_0003);
    ev_v <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("ready", 32'h0000_0000, {31'h0, ev_rdy});
    ev_v <= 1'b0;
    $display("test regs done");
  endtask
  task automatic t_single();
    wb(1'b1, rdq_pkg::OFF_MASTER_CONFIG, 32'h0000_0001);
    ev(8'h05, 1'b1, 3'h0);
    waitw(32'h0000_0001);
    chk("addr", BASE, laddr);
    chk("entry", ent(8'h05, 1'b1, 3'h0), ldata);
    rd(rdq_pkg::OFF_ENGINE_WRITE_PTR, 32'h0000_0001, "wp");
    rd(rdq_pkg::OFF_DMA_STATUS, 32'h0000_0001, "status");
    chk("done", 32'h0000_0001, {31'h0, dwf});
    ev(8'h06, 1'b1, 3'h0);
    ev(8'h07, 1'b1, 3'h0);
    waitw(32'h0000_0003);
    wb(1'b1, rdq_pkg::OFF_DMA_STATUS, 32'h0000_0003);
    ev(8'h08, 1'b1, 3'h0);
    repeat (20) @(posedge clk_i);
    chk("words", 32'h0000_0003, words);
    rd(rdq_pkg::OFF_DMA_STATUS, 32'h0000_0002, "status");
    rd(rdq_pkg::OFF_ENGINE_WRITE_PTR, 32'h0000_0003, "wp");
    wb(1'b1, rdq_pkg::OFF_INT_ENABLE, 32'h0000_0002);
    repeat (2) @(posedge clk_i);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    chk("ovf", 32'h0000_0001, {31'h0, dof});
    wb(1'b1, rdq_pkg::OFF_HOST_READ_PTR, 32'h0000_0003);
    ev(8'h09, 1'b1, 3'h0);
    waitw(32'h0000_0004);
    chk("addr", BASE + 32'h0000_000C, laddr);
    rd(rdq_pkg::OFF_ENGINE_WRITE_PTR, 32'h0000_0000, "wp");
    ev(8'h0A, 1'b0, 3'h2);
    repeat (20) @(posedge clk_i);
    chk("words", 32'h0000_0004, words);
    ev(8'h0A, 1'b0, 3'h2);
    waitw(32'h0000_0005);
    chk("entry", ent(8'h0A, 1'b0, 3'h2), ldata);
    chk("last", 32'h0000_0005, n_last);
    $display("test single done");
  endtask
  task automatic t_burst();
    wb(1'b1, rdq_pkg::OFF_END_INDEX, 32'h0000_000F);
    wb(1'b1, rdq_pkg::OFF_HOST_READ_PTR, 32'h0000_0000);
    wb(1'b1, rdq_pkg::OFF_ENGINE_WRITE_PTR, 32'h0000_0000);
    wb(1'b1, rdq_pkg::OFF_FLUSH_TIMER, 32'h0000_0002);
    wb(1'b1, rdq_pkg::OFF_RX_QUEUE_CTRL, 32'h0000_0110);
    for (int i = 0; i < 5; i++) ev(8'(i), 1'b1, 3'h0);
    repeat (30) @(posedge clk_i);
    chk("words", 32'h0000_0005, words);
    ev(8'h05, 1'b1, 3'h0);
    waitw(32'h0000_000B);
    chk("last", 32'h0000_0006, n_last);
    rd(rdq_pkg::OFF_ENGINE_WRITE_PTR, 32'h0000_0006, "wp");
    chk("addr", BASE + 32'h0000_0014, laddr);
    wb(1'b1, rdq_pkg::OFF_DMA_STATUS, 32'h0000_0003);
    ev(8'h01, 1'b1, 3'h0);
    waitw(32'h0000_000C);
    rd(rdq_pkg::OFF_DMA_STATUS, 32'h0000_0000, "status");
    ev(8'h02, 1'b1, 3'h0);
    wb(1'b1, rdq_pkg::OFF_RX_QUEUE_CTRL, 32'h0000_0130);
    waitw(32'h0000_000D);
    rd(rdq_pkg::OFF_DMA_STATUS, 32'h0000_0001, "status");
    wb(1'b1, rdq_pkg::OFF_RX_QUEUE_CTRL, 32'h0000_0110);
    $display("test burst done");
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_single();
    t_burst();
    final_report();
  end
endmodule
`default_nettype wire
